// ### hdl/wkrx_map.svh
`ifndef WKRX_MAP_SVH
`define WKRX_MAP_SVH

// Register indices; byte address is four times the index
`define WKRX_IDX_CHAN      6'd0
`define WKRX_IDX_GAIN      6'd1
`define WKRX_IDX_TOL       6'd2
`define WKRX_IDX_SLICE     6'd3
`define WKRX_IDX_OFFT      6'd4
`define WKRX_IDX_PAT2      6'd5
`define WKRX_IDX_PAT1      6'd6
`define WKRX_IDX_TOBR      6'd7
`define WKRX_IDX_AWAKE     6'd8
`define WKRX_IDX_RSV9      6'd9
`define WKRX_IDX_STR1      6'd10
`define WKRX_IDX_STR2      6'd11
`define WKRX_IDX_STR3      6'd12
`define WKRX_IDX_FWC       6'd13
`define WKRX_IDX_CMD       6'd14

// Direct command codes, written to the command register
`define WKRX_CMD_CLR_WAKE  6'h00
`define WKRX_CMD_RST_RSSI  6'h01
`define WKRX_CMD_TRIM_OSC  6'h02
`define WKRX_CMD_CLR_FALSE 6'h03
`define WKRX_CMD_PRESET    6'h04

// Reset values
`define WKRX_RST_CHAN      8'h0e
`define WKRX_RST_GAIN      8'h23
`define WKRX_RST_TOL       8'h00
`define WKRX_RST_SLICE     8'h20
`define WKRX_RST_OFFT      8'h10
`define WKRX_RST_PAT2      8'h69
`define WKRX_RST_PAT1      8'h96
`define WKRX_RST_TOBR      8'h0b
`define WKRX_RST_AWAKE     8'h00

// Writable bit masks; reserved bits read as zero
`define WKRX_WM_CHAN       8'h3f
`define WKRX_WM_GAIN       8'hf7
`define WKRX_WM_TOL        8'he3
`define WKRX_WM_AWAKE      8'h07

// Field positions
`define WKRX_B_DUTY        5
`define WKRX_B_SCAN        4
`define WKRX_B_EN2         3
`define WKRX_B_EN3         2
`define WKRX_B_EN1         1
`define WKRX_B_PWD         0
`define WKRX_B_ABSREF      7
`define WKRX_B_FIRST       6
`define WKRX_B_BIDIR       5
`define WKRX_B_DAMP        4
`define WKRX_B_DOUBLE      2
`define WKRX_B_CORR        1
`define WKRX_B_OSC         0
`define WKRX_B_THRED       7
`define WKRX_B_HYS20       7
`define WKRX_B_HYSPOS      6

// Timing
`define WKRX_CLK_PERIOD_NS 8
`define WKRX_SLOT_NS       1000000
`define WKRX_SLOT_CYC \
	((`WKRX_SLOT_NS + `WKRX_CLK_PERIOD_NS - 1) / `WKRX_CLK_PERIOD_NS)
`define WKRX_WAKE_NS       128000
`define WKRX_WAKE_CYC      (`WKRX_WAKE_NS / `WKRX_CLK_PERIOD_NS)

// Artificial wake-up intervals in 1 ms slots
`define WKRX_AW_MS_1       23'd1000
`define WKRX_AW_MS_2       23'd5000
`define WKRX_AW_MS_3       23'd20000
`define WKRX_AW_MS_4       23'd120000
`define WKRX_AW_MS_5       23'd900000
`define WKRX_AW_MS_6       23'd3600000
`define WKRX_AW_MS_7       23'd7200000

`endif

// ### hdl/wkrx_pkg.sv
package wkrx_pkg;

	// Channel slot of the scanning rotation
	typedef enum logic [3:0] {
		WKRX_SCAN_ALL = 4'b0001,
		WKRX_SCAN_CH1 = 4'b0010,
		WKRX_SCAN_CH3 = 4'b0100,
		WKRX_SCAN_CH2 = 4'b1000
	} wkrx_scan_e;

	typedef logic [8:0][7:0] wkrx_cfg_t;

	// Whole state of the register bank
	typedef struct packed {
		wkrx_cfg_t  cfg;
		logic [7:0] fwc;
		logic       ack;
		logic [7:0] rdat;
		logic [16:0] tick;
		logic       duty_on;
		logic [3:0] duty_left;
		wkrx_scan_e scan;
		logic [22:0] aw_cnt;
		logic [13:0] pulse_cnt;
		logic       pat_wake;
		logic       hit_seen;
		logic [2:0] chan_on;
		logic       rssi_rst;
		logic       trim;
	} wkrx_state_s;

endpackage

// ### hdl/wkrx_regs.sv
// Function
// - Duty-cycle bit switches active channels on and off periodically.
// - Off-time code 00..11 gives 1, 2, 4 or 8 ms off.
// - First-burst gain bit limits gain control to first burst.
// - Bidirectional gain bit lets gain rise and fall; resets set.
// - Double-pattern bit needs two pattern hits before wake.
// - Absolute-reference and threshold-reduction slicer bits, both reset clear.
// - Two-bit pattern tolerance field, resets to 00.
// - Two-bit frequency tolerance field, resets to 00.
// - Hysteresis size bit: clear 40 mV, set 20 mV.
// - Hysteresis edge bit: clear both edges, set rising only.
// - Slicer time constant resets 100, envelope time constant 000.
// - Five-bit bit-rate field, resets to 01011.
// - Registers addressed by six-bit index 0 to 14.
// - Restore-defaults command returns configuration registers 0 to 8 to defaults.
// - Clear-false command zeroes the false wake-up count.
// - Artificial wake with no activity gives 128 us wake pulse.
`include "wkrx_map.svh"
module wkrx_regs #(
	parameter int unsigned SLOT_CYC = `WKRX_SLOT_CYC,
	parameter int unsigned WAKE_CYC = `WKRX_WAKE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        activity_i,
	input  wire logic        pattern_hit_i,
	input  wire logic        false_wake_i,
	input  wire logic [4:0]  strength_ch1_val_i,
	input  wire logic [4:0]  strength_ch2_val_i,
	input  wire logic [4:0]  strength_ch3_val_i,
	output logic      [2:0]  chan_on_o,
	output logic             power_down_o,
	output logic             scan_mode_en_o,
	output logic             duty_cycle_en_o,
	output logic             slicer_abs_ref_o,
	output logic             gain_first_burst_only_o,
	output logic             gain_bidirectional_o,
	output logic             antenna_damper_en_o,
	output logic             double_pattern_en_o,
	output logic             correlator_en_o,
	output logic             osc_en_o,
	output logic             slicer_thresh_reduce_o,
	output logic      [1:0]  pattern_tolerance_o,
	output logic      [1:0]  freq_tolerance_o,
	output logic             hyst_small_o,
	output logic             hyst_rising_only_o,
	output logic      [2:0]  slicer_time_const_o,
	output logic      [2:0]  envelope_time_const_o,
	output logic      [1:0]  damping_res_o,
	output logic      [3:0]  gain_reduction_o,
	output logic      [15:0] wake_pattern_o,
	output logic      [2:0]  timeout_sel_o,
	output logic      [4:0]  bit_rate_sel_o,
	output logic             wake_o,
	output logic             rssi_reset_o,
	output logic             osc_trim_o
);

	// Default contents of the writable bank
	localparam wkrx_pkg::wkrx_cfg_t CFG_RST = {
		`WKRX_RST_AWAKE, `WKRX_RST_TOBR, `WKRX_RST_PAT1,
		`WKRX_RST_PAT2, `WKRX_RST_OFFT, `WKRX_RST_SLICE,
		`WKRX_RST_TOL, `WKRX_RST_GAIN, `WKRX_RST_CHAN};

	wkrx_pkg::wkrx_state_s st_reg;
	wkrx_pkg::wkrx_state_s st_next;

	logic [5:0] idx;
	logic       req;
	logic       wr;
	logic       tick_p;
	logic       cmd_wr;
	logic [5:0] cmd;
	logic [2:0] aw_code;

	// Writable bits of each bank register
	function automatic logic [7:0] wmask(input logic [5:0] i);
		case (i)
			`WKRX_IDX_CHAN:  wmask = `WKRX_WM_CHAN;
			`WKRX_IDX_GAIN:  wmask = `WKRX_WM_GAIN;
			`WKRX_IDX_TOL:   wmask = `WKRX_WM_TOL;
			`WKRX_IDX_AWAKE: wmask = `WKRX_WM_AWAKE;
			default:         wmask = 8'hff;
		endcase
	endfunction

	// Interval in 1 ms slots for an artificial wake code
	function automatic logic [22:0] aw_limit(input logic [2:0] c);
		case (c)
			3'h1:    aw_limit = `WKRX_AW_MS_1;
			3'h2:    aw_limit = `WKRX_AW_MS_2;
			3'h3:    aw_limit = `WKRX_AW_MS_3;
			3'h4:    aw_limit = `WKRX_AW_MS_4;
			3'h5:    aw_limit = `WKRX_AW_MS_5;
			3'h6:    aw_limit = `WKRX_AW_MS_6;
			3'h7:    aw_limit = `WKRX_AW_MS_7;
			default: aw_limit = 23'h000000;
		endcase
	endfunction

	// Channels let through by a scan slot, ordered ch3, ch2, ch1
	function automatic logic [2:0] scan_mask(input wkrx_pkg::wkrx_scan_e s);
		case (s)
			wkrx_pkg::WKRX_SCAN_CH1: scan_mask = 3'h1;
			wkrx_pkg::WKRX_SCAN_CH2: scan_mask = 3'h2;
			wkrx_pkg::WKRX_SCAN_CH3: scan_mask = 3'h4;
			default:                 scan_mask = 3'h7;
		endcase
	endfunction

	// Bus decode
	// Six-bit register index
	assign idx     = wb_adr_i[7:2];
	assign req     = wb_cyc_i && wb_stb_i && !st_reg.ack;
	assign wr      = req && wb_we_i && wb_sel_i[0];
	assign cmd_wr  = wr && (idx == `WKRX_IDX_CMD);
	assign cmd     = wb_dat_i[5:0];
	assign aw_code = st_reg.cfg[`WKRX_IDX_AWAKE][2:0];
	assign tick_p  = (st_reg.tick == 17'(SLOT_CYC - 1));

	// Next state of the whole bank
	always_comb begin
		st_next          = st_reg;
		st_next.ack      = req;
		st_next.rdat     = 8'h00;
		st_next.rssi_rst = 1'b0;
		st_next.trim     = 1'b0;
		st_next.tick     = tick_p ? 17'h00000 : st_reg.tick + 17'h00001;

		// Read mux
		// Reserved and unmapped read zero
		if (req && !wb_we_i) begin
			if (idx <= `WKRX_IDX_AWAKE)
				st_next.rdat = st_reg.cfg[idx[3:0]];
			else if (idx == `WKRX_IDX_STR1)
				st_next.rdat = {3'h0, strength_ch1_val_i};
			else if (idx == `WKRX_IDX_STR2)
				st_next.rdat = {3'h0, strength_ch2_val_i};
			else if (idx == `WKRX_IDX_STR3)
				st_next.rdat = {3'h0, strength_ch3_val_i};
			else if (idx == `WKRX_IDX_FWC)
				st_next.rdat = st_reg.fwc;
		end

		// Register writes
		// Read-only indices ignore writes
		if (wr && idx <= `WKRX_IDX_AWAKE) begin
			st_next.cfg[idx[3:0]] = wb_dat_i[7:0] & wmask(idx);
		end

		// Direct commands
		// Restore defaults
		if (cmd_wr && cmd == `WKRX_CMD_PRESET) begin
			st_next.cfg = CFG_RST;
		end
		if (cmd_wr && cmd == `WKRX_CMD_RST_RSSI) begin
			st_next.rssi_rst = 1'b1;
		end
		if (cmd_wr && cmd == `WKRX_CMD_TRIM_OSC) begin
			st_next.trim = 1'b1;
		end

		// False wake-up count, event wins over clear
		// Clear false count
		if (cmd_wr && cmd == `WKRX_CMD_CLR_FALSE) begin
			st_next.fwc = 8'h00;
		end
		if (false_wake_i && st_next.fwc != 8'hff) begin
			st_next.fwc = st_next.fwc + 8'h01;
		end

		// Pattern wake; a hit in the clearing cycle survives
		if (cmd_wr && cmd == `WKRX_CMD_CLR_WAKE) begin
			st_next.pat_wake = 1'b0;
			st_next.hit_seen = 1'b0;
		end
		// Two hits when double pattern set
		if (pattern_hit_i && st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_CORR]) begin
			if (st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_DOUBLE] &&
			    !st_reg.hit_seen) begin
				st_next.hit_seen = 1'b1;
			end else begin
				st_next.pat_wake = 1'b1;
				st_next.hit_seen = 1'b0;
			end
		end

		// Duty-cycled listening: one slot on, off for the chosen time
		// Periodic on and off
		if (!st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_DUTY]) begin
			st_next.duty_on   = 1'b1;
			st_next.duty_left = 4'h0;
		end else if (tick_p) begin
			if (st_reg.duty_left <= 4'h1) begin
				st_next.duty_on = !st_reg.duty_on;
				// Off time 1, 2, 4, 8 ms
				st_next.duty_left = st_reg.duty_on ?
					4'h1 << st_reg.cfg[`WKRX_IDX_OFFT][7:6] : 4'h1;
			end else begin
				st_next.duty_left = st_reg.duty_left - 4'h1;
			end
		end

		// Scanning rotation ch1, ch3, ch2 until a carrier is seen
		if (!st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_SCAN] || activity_i) begin
			st_next.scan = wkrx_pkg::WKRX_SCAN_ALL;
		end else if (tick_p) begin
			case (st_reg.scan)
				wkrx_pkg::WKRX_SCAN_CH1: st_next.scan = wkrx_pkg::WKRX_SCAN_CH3;
				wkrx_pkg::WKRX_SCAN_CH3: st_next.scan = wkrx_pkg::WKRX_SCAN_CH2;
				default:                 st_next.scan = wkrx_pkg::WKRX_SCAN_CH1;
			endcase
		end

		// Channel power from enables, power-down, duty and scan slot
		st_next.chan_on = {st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_EN3],
			st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_EN2],
			st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_EN1]} &
			{3{!st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_PWD]}} &
			{3{st_reg.duty_on}} & scan_mask(st_reg.scan);

		// Wake pulse countdown
		if (st_reg.pulse_cnt != 14'h0000) begin
			st_next.pulse_cnt = st_reg.pulse_cnt - 14'h0001;
		end
		if (aw_code == 3'h0 || activity_i ||
		    st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_PWD]) begin
			st_next.aw_cnt = 23'h000000;
		end else if (tick_p) begin
			if (st_reg.aw_cnt + 23'h000001 >= aw_limit(aw_code)) begin
				st_next.aw_cnt = 23'h000000;
				st_next.pulse_cnt = 14'(WAKE_CYC);
			end else begin
				st_next.aw_cnt = st_reg.aw_cnt + 23'h000001;
			end
		end
	end

	// State register
	// Reset defaults of the bank
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg           <= '0;
			st_reg.cfg       <= CFG_RST;
			st_reg.duty_on   <= 1'b1;
			st_reg.scan      <= wkrx_pkg::WKRX_SCAN_ALL;
			st_reg.chan_on   <= 3'h0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Bus outputs
	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = {24'h000000, st_reg.rdat};

	// Configuration fields to the front end
	// First-burst gain control
	assign gain_first_burst_only_o = st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_FIRST];
	assign gain_bidirectional_o = st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_BIDIR];
	assign slicer_abs_ref_o = st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_ABSREF];
	assign slicer_thresh_reduce_o = st_reg.cfg[`WKRX_IDX_TOL][`WKRX_B_THRED];
	assign pattern_tolerance_o = st_reg.cfg[`WKRX_IDX_TOL][6:5];
	assign freq_tolerance_o = st_reg.cfg[`WKRX_IDX_TOL][1:0];
	assign hyst_small_o = st_reg.cfg[`WKRX_IDX_SLICE][`WKRX_B_HYS20];
	assign hyst_rising_only_o = st_reg.cfg[`WKRX_IDX_SLICE][`WKRX_B_HYSPOS];
	assign slicer_time_const_o = st_reg.cfg[`WKRX_IDX_SLICE][5:3];
	assign envelope_time_const_o = st_reg.cfg[`WKRX_IDX_SLICE][2:0];
	assign wake_pattern_o = {st_reg.cfg[`WKRX_IDX_PAT1],
		st_reg.cfg[`WKRX_IDX_PAT2]};
	assign bit_rate_sel_o = st_reg.cfg[`WKRX_IDX_TOBR][4:0];
	assign timeout_sel_o = st_reg.cfg[`WKRX_IDX_TOBR][7:5];
	assign damping_res_o = st_reg.cfg[`WKRX_IDX_OFFT][5:4];
	assign gain_reduction_o = st_reg.cfg[`WKRX_IDX_OFFT][3:0];
	assign power_down_o = st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_PWD];
	assign scan_mode_en_o = st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_SCAN];
	assign duty_cycle_en_o = st_reg.cfg[`WKRX_IDX_CHAN][`WKRX_B_DUTY];
	assign antenna_damper_en_o = st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_DAMP];
	assign double_pattern_en_o = st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_DOUBLE];
	assign correlator_en_o = st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_CORR];
	assign osc_en_o = st_reg.cfg[`WKRX_IDX_GAIN][`WKRX_B_OSC];

	// Channel power, wake and command pulses
	assign chan_on_o    = st_reg.chan_on;
	assign wake_o       = (st_reg.pulse_cnt != 14'h0000) || st_reg.pat_wake;
	assign rssi_reset_o = st_reg.rssi_rst;
	assign osc_trim_o   = st_reg.trim;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence cmd_seq(logic [5:0] c);
		cmd_wr && cmd == c;
	endsequence

	sequence ro_write_seq;
		wr && idx >= `WKRX_IDX_STR1 && idx <= `WKRX_IDX_FWC;
	endsequence

	// Without duty or scan, channels follow the enables
	duty_plain_a: assert property (
		!duty_cycle_en_o && !scan_mode_en_o && !power_down_o &&
		$stable(st_reg.cfg[`WKRX_IDX_CHAN]) |=>
		chan_on_o == {$past(st_reg.cfg[`WKRX_IDX_CHAN][2]),
			$past(st_reg.cfg[`WKRX_IDX_CHAN][3]),
			$past(st_reg.cfg[`WKRX_IDX_CHAN][1])})
		else $error("channels not following enables");

	// Off phase loads two to the power of the code
	offtime_load_a: assert property (
		duty_cycle_en_o && $fell(st_reg.duty_on) |->
		st_reg.duty_left == 4'h1 << $past(st_reg.cfg[`WKRX_IDX_OFFT][7:6]))
		else $error("off time length wrong");

	// Second hit needed under double pattern
	double_hit_a: assert property (
		$rose(st_reg.pat_wake) && $past(double_pattern_en_o) |->
		$past(st_reg.hit_seen))
		else $error("wake on single pattern hit");

	// Read-only registers keep the bank unchanged
	ro_ignore_a: assert property (
		ro_write_seq |=> st_reg.cfg == $past(st_reg.cfg))
		else $error("write to read-only index changed bank");

	// Unmapped reads answer zero
	unmapped_zero_a: assert property (
		req && !wb_we_i && idx > `WKRX_IDX_FWC |=>
		wb_ack_o && wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");

	// Restore defaults
	preset_bank_a: assert property (
		cmd_seq(`WKRX_CMD_PRESET) |=> st_reg.cfg == CFG_RST)
		else $error("defaults not restored");

	// Clear of false count
	clear_false_a: assert property (
		cmd_seq(`WKRX_CMD_CLR_FALSE) |=>
		st_reg.fwc == {7'h00, $past(false_wake_i)})
		else $error("false count not cleared");

	// Wake pulse loaded with full length
	wake_len_a: assert property (
		$rose(st_reg.pulse_cnt != 14'h0000) |->
		st_reg.pulse_cnt == 14'(WAKE_CYC))
		else $error("wake pulse length wrong");

	// No artificial wake when disabled
	aw_off_a: assert property (
		aw_code == 3'h0 && st_reg.pulse_cnt == 14'h0000 |=>
		st_reg.pulse_cnt == 14'h0000)
		else $error("artificial wake while disabled");

	// Bus answers one cycle after a request, then drops
	bus_ack_a: assert property (
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer timing wrong");

endmodule

// ### testbench/test_wkrx_regs.sv
`include "wkrx_map.svh"
module test_wkrx_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 20;
	localparam int WC = 5;
	localparam logic [7:0] RST [9] = '{`WKRX_RST_CHAN, `WKRX_RST_GAIN,
		`WKRX_RST_TOL, `WKRX_RST_SLICE, `WKRX_RST_OFFT, `WKRX_RST_PAT2,
		`WKRX_RST_PAT1, `WKRX_RST_TOBR, `WKRX_RST_AWAKE};
	localparam logic [7:0] MSK [9] = '{`WKRX_WM_CHAN, `WKRX_WM_GAIN,
		`WKRX_WM_TOL, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, `WKRX_WM_AWAKE};
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i, q, d, m [9], ro [5];
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        activity_i = 1'b0, pattern_hit_i = 1'b0;
	logic        false_wake_i = 1'b0;
	logic [4:0]  strength_ch1_val_i = 5'h0, strength_ch2_val_i = 5'h0;
	logic [4:0]  strength_ch3_val_i = 5'h0, bit_rate_sel_o;
	logic [2:0]  chan_on_o, slicer_time_const_o, envelope_time_const_o;
	logic [2:0]  timeout_sel_o;
	logic [1:0]  pattern_tolerance_o, freq_tolerance_o, damping_res_o;
	logic [3:0]  gain_reduction_o;
	logic [15:0] wake_pattern_o;
	logic        power_down_o, scan_mode_en_o, duty_cycle_en_o;
	logic        slicer_abs_ref_o, gain_first_burst_only_o, osc_en_o;
	logic        gain_bidirectional_o, antenna_damper_en_o, wake_o;
	logic        double_pattern_en_o, correlator_en_o, hyst_small_o;
	logic        slicer_thresh_reduce_o, hyst_rising_only_o;
	logic        rssi_reset_o, osc_trim_o;
	int          failures = 0, num_checks = 0, nr = 0, nt = 0, n, len, e;

	wkrx_regs #(.SLOT_CYC(SC), .WAKE_CYC(WC)) dut (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .activity_i, .pattern_hit_i, .false_wake_i,
		.strength_ch1_val_i, .strength_ch2_val_i, .strength_ch3_val_i,
		.chan_on_o, .power_down_o, .scan_mode_en_o, .duty_cycle_en_o,
		.slicer_abs_ref_o, .gain_first_burst_only_o, .gain_bidirectional_o,
		.antenna_damper_en_o, .double_pattern_en_o, .correlator_en_o,
		.osc_en_o, .slicer_thresh_reduce_o, .pattern_tolerance_o,
		.freq_tolerance_o, .hyst_small_o, .hyst_rising_only_o,
		.slicer_time_const_o, .envelope_time_const_o, .damping_res_o,
		.gain_reduction_o, .wake_pattern_o, .timeout_sel_o,
		.bit_rate_sel_o, .wake_o, .rssi_reset_o, .osc_trim_o);

	wkrx_host h (.clk_i, .ack_i(wb_ack_o), .rdat_i(wb_dat_o),
		.cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
		.adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

	// Clock, 8 ns period
	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// Count command pulses, one per cycle high
	always @(posedge clk_i) begin
		if (rssi_reset_o === 1'b1) nr++;
		if (osc_trim_o === 1'b1) nt++;
	end

	task automatic chk(input string nm, input logic [15:0] ex,
			input logic [15:0] got);
		num_checks++;
		if (got !== ex) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// Read back every configuration byte against the model
	task automatic rdall();
		for (int i = 0; i < 9; i++) begin
			h.rd(6'(i), q);
			chk("reg", 16'(m[i]), 16'(q));
		end
	endtask

	// Field outputs against the model bytes
	task automatic outs();
		chk("r0", 16'({m[0][5:4], m[0][0]}), 16'({duty_cycle_en_o,
			scan_mode_en_o, power_down_o}));
		chk("r1", 16'(m[1]), 16'({slicer_abs_ref_o, gain_first_burst_only_o,
			gain_bidirectional_o, antenna_damper_en_o, 1'b0,
			double_pattern_en_o, correlator_en_o, osc_en_o}));
		chk("r2", 16'(m[2]), 16'({slicer_thresh_reduce_o, pattern_tolerance_o,
			3'h0, freq_tolerance_o}));
		chk("r3", 16'(m[3]), 16'({hyst_small_o, hyst_rising_only_o,
			slicer_time_const_o, envelope_time_const_o}));
		chk("r4", 16'(m[4][5:0]), 16'({damping_res_o, gain_reduction_o}));
		chk("pat", {m[6], m[5]}, wake_pattern_o);
		chk("r7", 16'(m[7]), 16'({timeout_sel_o, bit_rate_sel_o}));
	endtask

	// One-cycle front-end pulse: pattern hit or false wake
	task automatic fe(input bit p);
		@(posedge clk_i);
		if (p) pattern_hit_i <= 1'b1;
		else false_wake_i <= 1'b1;
		@(posedge clk_i);
		pattern_hit_i <= 1'b0;
		false_wake_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic results();
		if (failures == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (60000) @(posedge clk_i);
		failures++;
		results();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h60d4));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		m = RST;
		repeat (3) @(posedge clk_i);
		chk("chan_on", 16'h7, 16'(chan_on_o));
		rdall();
		outs();
		repeat (3) begin
			for (int i = 0; i < 9; i++) begin
				d = 8'($urandom);
				h.wr(6'(i), d);
				m[i] = d & MSK[i];
			end
			rdall();
			outs();
		end
		ro[0] = 8'h00;
		ro[1] = 8'($urandom % 32);
		ro[2] = 8'($urandom % 32);
		ro[3] = 8'($urandom % 32);
		strength_ch1_val_i <= ro[1][4:0];
		strength_ch2_val_i <= ro[2][4:0];
		strength_ch3_val_i <= ro[3][4:0];
		n = 3 + $urandom % 6;
		ro[4] = 8'(n);
		repeat (n) fe(1'b0);
		for (int i = 9; i < 14; i++) h.wr(6'(i), 8'hff);
		h.wr(6'd20, 8'hff);
		for (int i = 9; i < 14; i++) begin
			h.rd(6'(i), q);
			chk("ro", 16'(ro[i - 9]), 16'(q));
		end
		h.rd(6'd20, q);
		chk("unmapped", 16'h0, 16'(q));
		h.wr(6'd14, 8'h03);
		h.rd(6'd13, q);
		chk("fwc", 16'h0, 16'(q));
		h.wr(6'd14, 8'h04);
		m = RST;
		rdall();
		outs();
		h.wr(6'd14, 8'h01);
		h.wr(6'd14, 8'h02);
		@(posedge clk_i);
		chk("pulses", 16'h0101, 16'({8'(nr), 8'(nt)}));
		fe(1'b1);
		chk("wake", 16'h1, 16'(wake_o));
		h.wr(6'd14, 8'h00);
		repeat (2) @(posedge clk_i);
		chk("clear", 16'h0, 16'(wake_o));
		h.wr(6'd1, RST[1] | 8'h04);
		fe(1'b1);
		chk("wake1", 16'h0, 16'(wake_o));
		fe(1'b1);
		chk("wake2", 16'h1, 16'(wake_o));
		h.wr(6'd14, 8'h00);
		// Off run length for each off-time code
		for (int k = 0; k < 4; k++) begin
			h.wr(6'd4, 8'(k << 6) | 8'h10);
			h.wr(6'd0, 8'h2e);
			while (chan_on_o === 3'h0) @(posedge clk_i);
			while (chan_on_o !== 3'h0) @(posedge clk_i);
			len = 0;
			while (chan_on_o === 3'h0) begin
				@(posedge clk_i);
				len++;
			end
			e = (1 << k) * SC;
			if (len <= e + 1 && len + 1 >= e) len = e;
			chk("off", 16'(e), 16'(len));
			h.wr(6'd0, 8'h0e);
		end
		// Scan rotation ch1, ch3, ch2; all channels on with activity
		h.wr(6'd0, 8'h1e);
		while (chan_on_o !== 3'h1) @(posedge clk_i);
		while (chan_on_o === 3'h1) @(posedge clk_i);
		chk("scan3", 16'h4, 16'(chan_on_o));
		while (chan_on_o === 3'h4) @(posedge clk_i);
		chk("scan2", 16'h2, 16'(chan_on_o));
		activity_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("scan_all", 16'h7, 16'(chan_on_o));
		activity_i <= 1'b0;
		h.wr(6'd0, 8'h0e);
		chk("no_aw", 16'h0, 16'(wake_o));
		// Activity restarts the inactivity interval
		h.wr(6'd8, 8'h01);
		repeat (10000) @(posedge clk_i);
		activity_i <= 1'b1;
		@(posedge clk_i);
		activity_i <= 1'b0;
		len = 0;
		while (wake_o !== 1'b1) begin
			@(posedge clk_i);
			len++;
		end
		e = 1000 * SC;
		if (len <= e + SC && len + SC >= e) len = e;
		chk("aw", 16'(e), 16'(len));
		len = 0;
		while (wake_o === 1'b1) begin
			@(posedge clk_i);
			len++;
		end
		chk("aw_len", 16'(WC), 16'(len));
		// Reset in mid-run returns the bank to defaults
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		m = RST;
		rdall();
		results();
	end
endmodule

// ### testbench/wkrx_host.sv
module wkrx_host (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] rdat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bus idle from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// One classic cycle, held until ack is seen at an edge
	task automatic xfer(input logic w, input logic [5:0] i,
			input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {i, 2'b00};
		sel_o <= 4'h1;
		dat_o <= {24'h0, d};
		@(posedge clk_i);
		while (ack_i !== 1'b1) @(posedge clk_i);
		q = rdat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		dat_o <= ~{24'h0, d}; // Stale data is not left on the bus
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, i, d, q);
	endtask

	task automatic rd(input logic [5:0] i, output logic [7:0] q);
		xfer(1'b0, i, 8'h00, q);
	endtask
endmodule
